// ==== hdl/dsp_multiply_accumulate_datapath.sv ====
// Functional notes
// - Multiplier inputs are 17 bits, zero or sign extended per operand.
// - Scaler gives a fractional 1.31 product or a 32-bit integer product.
// - The 33-bit multiplier result is sign extended to 40 bits.
// - Fractional mode treats operands as Q15, product is 1.31.
// - Same multiplier does signed, unsigned and mixed integer multiplies.
// - Integer product: byte operands give 16 bits, word operands 32 bits.
// - 40-bit adder/subtracter uses one accumulator as source and target.
// - Add and load data may pass the barrel shifter first.
// - One adder input can be zero; the other gets true or inverted data.
// - Addition uses true data with carry input low.
// - Subtraction uses inverted data with active-low borrow input.
// - Overflow out of bit 39 is flagged as destroying the sign.
// - Guard overflow flags when bits 32 to 39 differ.
// - Saturation uses result, overflow, per-accumulator enable and mode bit.
// - Clip flag sets when its accumulator is clamped.
// - Combined flags are the OR of the two per-accumulator flags.
// - Overflow and clip status bits are latched as status outputs.
// - Guard flags are rewritten on every adder operation on their accumulator.
// - Guard overflow with its trap enable raises an arithmetic trap.
`timescale 1ns/1ps
`default_nettype none
module dsp_multiply_accumulate_datapath
    import mac_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Operation request from the decoder
    input wire logic i_op_valid,
    input wire op_t i_op_code,
    input wire logic i_acc_sel,
    input wire logic [15:0] i_op_a,
    input wire logic [15:0] i_op_b,
    input wire logic i_a_signed,
    input wire logic i_b_signed,
    input wire logic i_byte_mode,
    input wire logic [39:0] i_data,
    input wire logic [4:0] i_shift_amt,
    // Core control bits
    input wire logic i_frac_mode,
    input wire logic [1:0] i_clip_enable,
    input wire logic i_clip_mode_select,
    input wire logic [1:0] i_trap_enable,
    input wire logic [1:0] i_clip_flag_clear,
    // Accumulators and integer result
    output logic [39:0] o_acc_one,
    output logic [39:0] o_acc_two,
    output logic [31:0] o_int_result,
    output logic o_int_valid,
    // Status
    output logic o_accum_one_guard_overflow,
    output logic o_accum_two_guard_overflow,
    output logic o_accum_one_clip_flag,
    output logic o_accum_two_clip_flag,
    output logic o_any_guard_overflow,
    output logic o_any_clip_flag,
    output logic o_sign_lost,
    output logic o_arith_trap
);
    function automatic logic [15:0] ext_byte(input logic [7:0] v,
                                             input logic sgn);
        ext_byte = {{8{sgn & v[7]}}, v};
    endfunction

    function automatic logic bits_differ(input logic [8:0] v);
        bits_differ = (v != 9'h000) && (v != 9'h1ff);
    endfunction

    function automatic logic [39:0] sat_limit(input logic wide,
                                              input logic neg);
        if (wide)
            sat_limit = neg ? SAT39_NEG : SAT39_POS;
        else
            sat_limit = neg ? SAT31_NEG : SAT31_POS;
    endfunction

    mul_if mul_bus ();

    mul_scaler u_mul
    (
        .bus(mul_bus.calc)
    );

    logic is_mac;
    logic is_sub;
    logic is_add;
    logic is_load;
    logic is_int;
    logic exec;

    assign is_sub = (i_op_code == OP_MAC_SUB);
    assign is_mac = (i_op_code == OP_MAC_ADD) || is_sub;
    assign is_add = (i_op_code == OP_ADD_ACC);
    assign is_load = (i_op_code == OP_LOAD);
    assign is_int = (i_op_code == OP_INT_MUL);
    assign exec = i_op_valid && (is_mac || is_add || is_load);

    // Multiplier operands
    assign mul_bus.a = (is_int && i_byte_mode)
        ? ext_byte(i_op_a[7:0], i_a_signed) : i_op_a;
    assign mul_bus.b = (is_int && i_byte_mode)
        ? ext_byte(i_op_b[7:0], i_b_signed) : i_op_b;
    assign mul_bus.a_signed = i_a_signed;
    assign mul_bus.b_signed = i_b_signed;
    assign mul_bus.frac = i_frac_mode && !is_int;

    // Barrel shifter: positive count shifts right, negative shifts left
    logic [4:0] shl_cnt;
    logic [39:0] shifted;

    assign shl_cnt = 5'h00 - i_shift_amt;
    assign shifted = i_shift_amt[4] ? (i_data << shl_cnt)
        : 40'($signed(i_data) >>> i_shift_amt);

    // Adder/subtracter
    logic [39:0] acc_reg [2];
    logic [39:0] acc_src;
    logic [39:0] operand;
    logic [39:0] a_side;
    logic [39:0] b_side;
    logic [40:0] sum41;
    logic [39:0] raw;
    logic carry_into39;
    logic cat_ovf;
    logic guard_ovf;
    logic bit31_ovf;
    logic true_neg;
    logic clip_en;
    logic need_clip;
    logic [39:0] result;

    assign acc_src = i_acc_sel ? acc_reg[1] : acc_reg[0];
    assign operand = is_mac ? mul_bus.product : shifted;
    assign a_side = is_load ? ACC_RESET : acc_src;
    assign b_side = is_sub ? ~operand : operand;
    // Carry in low for add; low borrow (carry 1) for subtract
    assign sum41 = {1'b0, a_side} + {1'b0, b_side}
        + {40'h00_0000_0000, is_sub};
    assign raw = sum41[39:0];
    assign carry_into39 = a_side[39] ^ b_side[39] ^ raw[39];
    assign cat_ovf = carry_into39 ^ sum41[40];
    assign guard_ovf = bits_differ({raw[39], raw[39:32]});
    assign bit31_ovf = bits_differ(raw[39:31]);
    // The true sign survives in the operands when bit 39 overflows
    assign true_neg = cat_ovf ? b_side[39] : raw[39];
    assign clip_en = i_clip_enable[i_acc_sel];
    assign need_clip = clip_en && (i_clip_mode_select ? cat_ovf
        : (cat_ovf || bit31_ovf));
    assign result = need_clip ? sat_limit(i_clip_mode_select, true_neg)
        : raw;

    // Per-accumulator state
    logic guard_reg [2];
    logic clip_reg [2];
    logic guard_next [2];
    logic clip_next [2];
    logic trap_hit [2];

    genvar k;
    generate
        for (k = 0; k < 2; k++)
        begin : g_acc
            logic hit;
            logic [39:0] acc_next;

            assign hit = exec && (i_acc_sel == 1'(k));
            assign acc_next = hit ? result : acc_reg[k];
            assign guard_next[k] = hit ? guard_ovf : guard_reg[k];
            // Hardware set wins over a clear in the same cycle
            assign clip_next[k] = (hit && need_clip)
                || (clip_reg[k] && !i_clip_flag_clear[k]);
            assign trap_hit[k] = hit && guard_ovf && i_trap_enable[k];

            always_ff @(posedge i_clk or posedge i_rst)
            begin
                if (i_rst)
                begin
                    acc_reg[k] <= ACC_RESET;
                    guard_reg[k] <= 1'b0;
                    clip_reg[k] <= 1'b0;
                end
                else
                begin
                    acc_reg[k] <= acc_next;
                    guard_reg[k] <= guard_next[k];
                    clip_reg[k] <= clip_next[k];
                end
            end
        end
    endgenerate

    // Summary status, integer result and trap
    logic any_guard_reg;
    logic any_clip_reg;
    logic sign_lost_reg;
    logic trap_reg;
    logic [31:0] int_result_reg;
    logic int_valid_reg;
    logic [31:0] int_next;

    assign int_next = i_byte_mode ? {16'h0000, mul_bus.product[15:0]}
        : mul_bus.product[31:0];

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            any_guard_reg <= 1'b0;
            any_clip_reg <= 1'b0;
            sign_lost_reg <= 1'b0;
            trap_reg <= 1'b0;
            int_result_reg <= 32'h0000_0000;
            int_valid_reg <= 1'b0;
        end
        else
        begin
            any_guard_reg <= guard_next[0] | guard_next[1];
            any_clip_reg <= clip_next[0] | clip_next[1];
            sign_lost_reg <= exec ? cat_ovf : sign_lost_reg;
            trap_reg <= trap_hit[0] | trap_hit[1];
            int_valid_reg <= i_op_valid && is_int;
            if (i_op_valid && is_int)
                int_result_reg <= int_next;
        end
    end

    assign o_acc_one = acc_reg[0];
    assign o_acc_two = acc_reg[1];
    assign o_accum_one_guard_overflow = guard_reg[0];
    assign o_accum_two_guard_overflow = guard_reg[1];
    assign o_accum_one_clip_flag = clip_reg[0];
    assign o_accum_two_clip_flag = clip_reg[1];
    assign o_any_guard_overflow = any_guard_reg;
    assign o_any_clip_flag = any_clip_reg;
    assign o_sign_lost = sign_lost_reg;
    assign o_arith_trap = trap_reg;
    assign o_int_result = int_result_reg;
    assign o_int_valid = int_valid_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_product_sign_ext: assert property (
        mul_bus.product[39:33] == {7{mul_bus.product[32]}})
        else $error("product not sign extended");
    a_int_word_result: assert property (
        i_op_valid && is_int && !i_byte_mode
        |=> o_int_valid && o_int_result == $past(mul_bus.product[31:0]))
        else $error("integer word result wrong");
    a_int_byte_result: assert property (
        i_op_valid && is_int && i_byte_mode
        |=> o_int_result[31:16] == 16'h0000)
        else $error("integer byte result upper half not zero");
    a_other_acc_holds: assert property (
        exec && !i_acc_sel |=> $stable(o_acc_two))
        else $error("unselected accumulator changed");
    a_load_zero_side: assert property (
        exec && is_load && i_acc_sel && !need_clip
        |=> o_acc_two == $past(shifted))
        else $error("load did not ignore accumulator");
    a_mac_sub_borrow: assert property (
        exec && is_sub && !i_acc_sel && !i_clip_enable[0]
        |=> o_acc_one == $past(acc_reg[0] - mul_bus.product))
        else $error("subtract result wrong");
    a_unclipped_store: assert property (
        exec && !i_acc_sel && !i_clip_enable[0]
        |=> o_acc_one == $past(raw))
        else $error("unclamped sum not stored");
    a_clamp_normal: assert property (
        exec && !i_acc_sel && i_clip_enable[0] && !i_clip_mode_select
        && bit31_ovf
        |=> o_acc_one == SAT31_POS || o_acc_one == SAT31_NEG)
        else $error("normal saturation value wrong");
    a_clip_flag_set: assert property (
        exec && i_acc_sel && need_clip |=> o_accum_two_clip_flag[*2]
        or (o_accum_two_clip_flag ##1 $past(i_clip_flag_clear[1])))
        else $error("clip flag not set");
    a_guard_tracks: assert property (
        exec && !i_acc_sel
        |=> o_accum_one_guard_overflow == $past(guard_ovf))
        else $error("guard flag not rewritten");
    a_any_guard_or: assert property (
        o_any_guard_overflow
        == (o_accum_one_guard_overflow | o_accum_two_guard_overflow))
        else $error("combined guard flag mismatch");
    a_any_clip_or: assert property (
        o_any_clip_flag == (o_accum_one_clip_flag | o_accum_two_clip_flag))
        else $error("combined clip flag mismatch");
    a_trap_cause: assert property (
        o_arith_trap |-> $past(exec && guard_ovf
        && i_trap_enable[i_acc_sel]))
        else $error("trap without enabled guard overflow");

    c_mac_clip: cover property (exec && is_mac && need_clip);
    c_sign_lost: cover property (exec && cat_ovf ##1 o_sign_lost);
    c_trap: cover property (o_arith_trap);
    c_int_byte: cover property (i_op_valid && is_int && i_byte_mode);
endmodule // dsp_multiply_accumulate_datapath
`default_nettype wire

// ==== hdl/mac_pkg.sv ====
`default_nettype none
package mac_pkg;
    localparam int ACC_W = 40;
    localparam int OPND_W = 16;
    localparam int PROD_W = 33;
    localparam int GUARD_LSB = 32;
    localparam int INT_W = 32;
    localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
    localparam logic [39:0] SAT31_POS = 40'h00_7fff_ffff;
    localparam logic [39:0] SAT31_NEG = 40'hff_8000_0000;
    localparam logic [39:0] SAT39_POS = 40'h7f_ffff_ffff;
    localparam logic [39:0] SAT39_NEG = 40'h80_0000_0000;

    // Operations selected by the instruction decoder
    typedef enum logic [2:0] {
        OP_NOP     = 3'b000,
        OP_MAC_ADD = 3'b001,
        OP_MAC_SUB = 3'b010,
        OP_ADD_ACC = 3'b011,
        OP_LOAD    = 3'b100,
        OP_INT_MUL = 3'b101
    } op_t;
endpackage
`default_nettype wire

// ==== hdl/mul_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface mul_if;
    logic [15:0] a;
    logic [15:0] b;
    logic a_signed;
    logic b_signed;
    logic frac;
    logic [39:0] product;

    modport calc
    (
        input a, b, a_signed, b_signed, frac,
        output product
    );
    modport user
    (
        output a, b, a_signed, b_signed, frac,
        input product
    );
endinterface
`default_nettype wire

// ==== hdl/mul_scaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module mul_scaler
(
    mul_if.calc bus
);
    logic signed [16:0] a17;
    logic signed [16:0] b17;
    logic signed [33:0] full;
    logic [32:0] scaled;

    assign a17 = {bus.a_signed & bus.a[15], bus.a};
    assign b17 = {bus.b_signed & bus.b[15], bus.b};
    assign full = a17 * b17;
    // Fractional result drops the duplicate sign bit
    assign scaled = bus.frac ? {full[31:0], 1'b0} : full[32:0];
    assign bus.product = {{7{scaled[32]}}, scaled};
endmodule // mul_scaler
`default_nettype wire

// ==== tb/reg_file_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module reg_file_model
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Integer product from the datapath
    input wire logic i_int_valid,
    input wire logic [31:0] i_int_result,
    // Working register pair
    output logic [15:0] o_w_lo,
    output logic [15:0] o_w_hi
);
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_w_lo <= 16'h0000;
            o_w_hi <= 16'h0000;
        end
        else if (i_int_valid)
        begin
            o_w_lo <= i_int_result[15:0];
            o_w_hi <= i_int_result[31:16];
        end
    end
endmodule // reg_file_model
`default_nettype wire

// ==== tb/test_dsp_multiply_accumulate_datapath.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_dsp_multiply_accumulate_datapath
    import mac_pkg::*;
;
    logic i_clk, i_rst, i_op_valid, i_acc_sel, i_a_signed, i_b_signed;
    logic i_byte_mode, i_frac_mode, i_clip_mode_select;
    op_t i_op_code;
    logic [15:0] i_op_a, i_op_b, w_lo, w_hi;
    logic [39:0] i_data, acc1, acc2;
    logic [4:0] i_shift_amt;
    logic [1:0] i_clip_enable, i_trap_enable, i_clip_flag_clear;
    logic [31:0] ir, eir, ew;
    logic iv, g1, g2, cf1, cf2, anyg, anyc, sl, trap, esl, etr, eiv;
    logic [39:0] ea [2];
    logic eg [2];
    logic ec [2];
    int err_count = 0;
    int checked = 0;

    dsp_multiply_accumulate_datapath DUT
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_op_valid(i_op_valid),
        .i_op_code(i_op_code), .i_acc_sel(i_acc_sel), .i_op_a(i_op_a),
        .i_op_b(i_op_b), .i_a_signed(i_a_signed), .i_b_signed(i_b_signed),
        .i_byte_mode(i_byte_mode), .i_data(i_data),
        .i_shift_amt(i_shift_amt), .i_frac_mode(i_frac_mode),
        .i_clip_enable(i_clip_enable),
        .i_clip_mode_select(i_clip_mode_select),
        .i_trap_enable(i_trap_enable),
        .i_clip_flag_clear(i_clip_flag_clear),
        .o_acc_one(acc1), .o_acc_two(acc2), .o_int_result(ir),
        .o_int_valid(iv), .o_accum_one_guard_overflow(g1),
        .o_accum_two_guard_overflow(g2), .o_accum_one_clip_flag(cf1),
        .o_accum_two_clip_flag(cf2), .o_any_guard_overflow(anyg),
        .o_any_clip_flag(anyc), .o_sign_lost(sl), .o_arith_trap(trap)
    );

    reg_file_model partner
    (
        .i_clk(i_clk), .i_rst(i_rst), .i_int_valid(iv),
        .i_int_result(ir), .o_w_lo(w_lo), .o_w_hi(w_hi)
    );

    always #2.5 i_clk = ~i_clk;

    function automatic logic [31:0] imul(logic [15:0] a, logic [15:0] b,
        logic sa, logic sb, logic bm);
        logic signed [16:0] x, y;
        logic signed [33:0] p;
        x = bm ? {{9{sa & a[7]}}, a[7:0]} : {sa & a[15], a};
        y = bm ? {{9{sb & b[7]}}, b[7:0]} : {sb & b[15], b};
        p = x * y;
        return bm ? {16'h0000, p[15:0]} : p[31:0];
    endfunction

    function automatic logic [39:0] prod(logic [15:0] a, logic [15:0] b,
        logic sa, logic sb, logic fr);
        logic signed [16:0] x, y;
        logic signed [33:0] p;
        logic [32:0] r;
        x = {sa & a[15], a};
        y = {sb & b[15], b};
        p = x * y;
        r = fr ? {p[31:0], 1'b0} : p[32:0];
        return {{7{r[32]}}, r};
    endfunction

    function automatic logic [39:0] shf(logic signed [39:0] d,
        logic signed [4:0] n);
        return (n < 0) ? d <<< (-n) : d >>> n;
    endfunction

    task automatic model;
        logic [39:0] x, y, s;
        logic [40:0] t;
        logic k, clamp, w;
        k = i_acc_sel;
        if (eiv)
            ew = eir;
        eiv = 0;
        etr = 0;
        for (int j = 0; j < 2; j++)
            ec[j] = ec[j] & ~i_clip_flag_clear[j];
        if (i_op_valid && i_op_code == OP_INT_MUL)
        begin
            eiv = 1;
            eir = imul(i_op_a, i_op_b, i_a_signed, i_b_signed, i_byte_mode);
        end
        else if (i_op_valid && i_op_code inside {[OP_MAC_ADD:OP_LOAD]})
        begin
            y = (i_op_code <= OP_MAC_SUB) ? prod(i_op_a, i_op_b, i_a_signed,
                i_b_signed, i_frac_mode) : shf(i_data, i_shift_amt);
            x = (i_op_code == OP_LOAD) ? 40'h00_0000_0000 : ea[k];
            t = {x[39], x} + {y[39], y};
            if (i_op_code == OP_MAC_SUB)
                t = {x[39], x} - {y[39], y};
            s = t[39:0];
            esl = t[40] ^ t[39];
            eg[k] = s[39:32] != 8'h00 && s[39:32] != 8'hff;
            w = i_clip_mode_select;
            clamp = i_clip_enable[k] && (esl || (!w && s[39:31] != 9'h000
                && s[39:31] != 9'h1ff));
            if (clamp)
                s = w ? (t[40] ? SAT39_NEG : SAT39_POS)
                    : (t[40] ? SAT31_NEG : SAT31_POS);
            ec[k] = ec[k] | clamp;
            ea[k] = s;
            etr = eg[k] & i_trap_enable[k];
        end
    endtask

    task automatic bad(logic [39:0] a, logic [39:0] e);
        checked++;
        if (a !== e)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, a, e);
        end
    endtask

    task automatic c40(logic [39:0] a, logic [39:0] e);
        bad(a, e);
    endtask

    task automatic c32(logic [31:0] a, logic [31:0] e);
        bad({8'h00, a}, {8'h00, e});
    endtask

    task automatic c1(logic a, logic e);
        bad({39'h0, a}, {39'h0, e});
    endtask

    task automatic check;
        c40(acc1, ea[0]);
        c40(acc2, ea[1]);
        c1(g1, eg[0]);
        c1(g2, eg[1]);
        c1(cf1, ec[0]);
        c1(cf2, ec[1]);
        c1(anyg, eg[0] | eg[1]);
        c1(anyc, ec[0] | ec[1]);
        c1(sl, esl);
        c1(trap, etr);
        c1(iv, eiv);
        c32(ir, eir);
        c32({w_hi, w_lo}, ew);
    endtask

    task automatic zero_model;
        ea = '{default: '0};
        eg = '{default: '0};
        ec = '{default: '0};
        {esl, etr, eiv, eir, ew} = '0;
    endtask

    // Operands lean toward full-scale values to reach the clamps
    task automatic drive;
        logic f;
        f = 1'($urandom);
        i_op_valid <= $urandom_range(7) != 0;
        i_op_code <= op_t'(3'($urandom_range(7)));
        i_acc_sel <= 1'($urandom);
        i_op_a <= ($urandom_range(3) == 0) ? 16'h8000 : 16'($urandom);
        i_op_b <= ($urandom_range(3) == 0) ? 16'h8000 : 16'($urandom);
        i_frac_mode <= f;
        i_a_signed <= f | 1'($urandom);
        i_b_signed <= f | 1'($urandom);
        i_byte_mode <= 1'($urandom);
        i_data <= 40'({$urandom, $urandom}) >> $urandom_range(39);
        i_shift_amt <= 5'($urandom);
        i_clip_enable <= 2'($urandom);
        i_clip_mode_select <= 1'($urandom);
        i_trap_enable <= 2'($urandom);
        i_clip_flag_clear <= ($urandom_range(7) == 0) ? 2'($urandom) : 2'h0;
    endtask

    task automatic run(int n);
        repeat (n)
        begin
            @(posedge i_clk);
            model();
            drive();
            @(negedge i_clk);
            check();
        end
    endtask

    // Directed corner: fixed operands of -1.0, or 0 as bytes, traps enabled
    task automatic step(op_t op, logic sel, logic [39:0] d, logic [1:0] ce,
        logic m, logic [1:0] clr, logic [4:0] sh = 5'h00);
        @(posedge i_clk);
        model();
        i_op_valid <= 1'b1;
        i_op_code <= op;
        i_acc_sel <= sel;
        i_data <= d;
        i_shift_amt <= sh;
        i_clip_enable <= ce;
        i_clip_mode_select <= m;
        i_trap_enable <= 2'h3;
        i_clip_flag_clear <= clr;
        {i_op_a, i_op_b} <= 32'h8000_8000;
        {i_a_signed, i_b_signed, i_frac_mode, i_byte_mode} <= 4'hf;
        @(negedge i_clk);
        check();
    endtask

    task automatic results;
        $display("Checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        {i_clk, i_op_valid, i_acc_sel, i_a_signed, i_b_signed} = '0;
        {i_byte_mode, i_frac_mode, i_clip_mode_select} = '0;
        {i_op_a, i_op_b, i_data, i_shift_amt} = '0;
        {i_clip_enable, i_trap_enable, i_clip_flag_clear} = '0;
        i_op_code = OP_NOP;
        i_rst = 1;
        zero_model();
        void'($urandom(70103));
        repeat (12) @(posedge i_clk);
        i_rst <= 0;
        step(OP_LOAD, 1'b0, 40'h7f_ffff_ffff, 2'h0, 1'b0, 2'h0);
        step(OP_ADD_ACC, 1'b0, 40'h00_0000_0001, 2'h0, 1'b0, 2'h0);
        step(OP_LOAD, 1'b1, 40'h7f_ffff_ffff, 2'h2, 1'b1, 2'h0);
        step(OP_ADD_ACC, 1'b1, 40'h00_0000_0001, 2'h2, 1'b1, 2'h0);
        step(OP_ADD_ACC, 1'b1, 40'h00_0000_0001, 2'h2, 1'b1, 2'h2);
        step(OP_MAC_ADD, 1'b0, 40'h00_0000_0000, 2'h1, 1'b0, 2'h2);
        step(OP_INT_MUL, 1'b0, 40'h00_0000_0000, 2'h0, 1'b0, 2'h3);
        step(OP_LOAD, 1'b1, 40'hff_ffff_fff0, 2'h0, 1'b0, 2'h0,
            5'h1c);
        step(OP_ADD_ACC, 1'b1, 40'h80_0000_0000, 2'h0, 1'b0, 2'h0,
            5'h0f);
        run(1500);
        @(posedge i_clk);
        i_rst <= 1;
        i_op_valid <= 0;
        zero_model();
        @(negedge i_clk);
        check();
        @(posedge i_clk);
        i_rst <= 0;
        run(300);
        results();
    end

    initial
    begin
        #50000;
        err_count++;
        results();
    end
endmodule // test_dsp_multiply_accumulate_datapath
`default_nettype wire
